// >>> src/acts_sequencer.v
// Slot and tag sequencer for a sixteen-slot audio codec link.
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "acts_defs.vh"
module acts_sequencer (
    input wire clk_sys,
    input wire nrst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_q,
    output reg irq_q,
    input wire bit_clk,
    input wire sdata_in,
    output reg sync_q,
    output reg sdata_out_q,
    output reg codec_ready_q
);
    localparam integer LATCH_N =
        `ACTS_RX_SLOTS * `ACTS_SLOT_BITS + `ACTS_TAG_WINDOW;
    localparam integer FRAME_N = `ACTS_TX_SLOTS * `ACTS_SLOT_BITS - 1;
    localparam integer WORD_N = `ACTS_SLOT_BITS - 1;
    localparam [7:0] LATCH_BIT = LATCH_N[7:0];
    localparam [7:0] FRAME_END = FRAME_N[7:0];
    localparam [3:0] WORD_END = WORD_N[3:0];

    wire [1:0] pin_level;
    wire [1:0] pin_rise;
    wire [1:0] pin_fall;

    acts_pin_sync #(.W(2)) u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pin({sdata_in, bit_clk}),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    wire bclk_rise = pin_rise[0];
    wire bclk_fall = pin_fall[0];
    wire din = pin_level[1];

    reg [3:0] ctrl_q;
    reg [2:0] mask_q;
    reg [2:0] stat_q;
    reg [2:0] stat_d;
    reg [15:0] stage_left_q;
    reg [15:0] stage_right_q;
    reg [15:0] rx_tag_q;
    reg [15:0] rx_s1_q;
    reg [15:0] rx_s2_q;
    reg [15:0] rx_left_q;
    reg [15:0] rx_right_q;
    reg [15:0] next_tag_q;
    reg [15:0] hold_tag_q;
    reg [15:0] hold_s1_q;
    reg [15:0] hold_s2_q;
    reg [15:0] hold_left_q;
    reg [15:0] hold_right_q;
    reg [15:0] rx_sh_q;
    reg [15:0] tx_sh_q;
    reg [7:0] cnt_q;
    reg [15:0] load_word;
    reg [15:0] tag_calc;
    reg [31:0] rd_mux;

    wire en = ctrl_q[`ACTS_C_EN];
    wire [7:0] cnt_nxt = cnt_q + 8'h01;
    wire [3:0] rx_slot = cnt_q[7:4];
    wire [15:0] rx_word = {rx_sh_q[14:0], din};
    wire rx_word_end = en && bclk_fall && (cnt_q[3:0] == WORD_END);
    wire rx_done = rx_word_end && (rx_slot == `ACTS_LAST_RX_SLOT);
    wire tag_latch = en && bclk_rise && (cnt_nxt == LATCH_BIT);
    wire in_late = en && (cnt_q >= LATCH_BIT);
    wire wr_txl = reg_wr && (reg_addr == `ACTS_A_TXL);
    wire wr_txr = reg_wr && (reg_addr == `ACTS_A_TXR);
    wire late_wr = in_late && (wr_txl || wr_txr);

    // Request flags sit five bits below the tag slot bits they enable.
    function [15:0] drq_to_tag;
        input [15:0] w;
        input active_low;
        reg [15:0] m;
        begin
            m = w & `ACTS_DRQ_MASK;
            if (active_low) begin
                m = m ^ `ACTS_DRQ_MASK;
            end
            drq_to_tag = m << `ACTS_DRQ_SHIFT;
        end
    endfunction

    // Next tag is worked out from the words kept from slots 0 to 2, as slot 4 completes.
    always @* begin
        tag_calc = `ACTS_TAG_FRAME;
        if (ctrl_q[`ACTS_C_INIT]) begin
            tag_calc = `ACTS_INIT_TAG;
        end else if (ctrl_q[`ACTS_C_MODE]) begin
            // The codec autodisplays its config register in slots 1 and 2.
            if (ctrl_q[`ACTS_C_SEL]) begin
                tag_calc = tag_calc | drq_to_tag(rx_s2_q, 1'b0);
            end else begin
                tag_calc = tag_calc | drq_to_tag(rx_s1_q, 1'b1);
            end
        end else begin
            // Only safe when ADC and DAC share one sample rate.
            tag_calc = tag_calc | (rx_tag_q & `ACTS_ADC_MASK);
        end
    end

    // Slots with no source carry zeros.
    always @* begin
        case (cnt_nxt[7:4])
            4'h0: load_word = hold_tag_q;
            4'h1: load_word = hold_s1_q;
            4'h2: load_word = hold_s2_q;
            `ACTS_LEFT_SLOT: load_word = hold_left_q;
            `ACTS_RIGHT_SLOT: load_word = hold_right_q;
            default: load_word = 16'h0000;
        endcase
    end

    // Bit counter and transmit shifter advance on bit clock rising edges.
    always @(posedge clk_sys) begin
        if (!nrst) begin
            cnt_q <= 8'hFF;
            tx_sh_q <= 16'h0000;
            sync_q <= 1'b0;
            sdata_out_q <= 1'b0;
        end else if (!en) begin
            cnt_q <= FRAME_END;
            tx_sh_q <= 16'h0000;
            sync_q <= 1'b0;
            sdata_out_q <= 1'b0;
        end else if (bclk_rise) begin
            cnt_q <= cnt_nxt;
            sync_q <= (cnt_nxt[7:4] == 4'h0);
            if (cnt_nxt[3:0] == 4'h0) begin
                tx_sh_q <= load_word;
                sdata_out_q <= load_word[15];
            end else begin
                tx_sh_q <= {tx_sh_q[14:0], 1'b0};
                sdata_out_q <= tx_sh_q[14];
            end
        end
    end

    // Receive words are caught on falling edges; only slots 0-4 are kept.
    always @(posedge clk_sys) begin
        if (!nrst) begin
            rx_sh_q <= 16'h0000;
            rx_tag_q <= 16'h0000;
            rx_s1_q <= 16'h0000;
            rx_s2_q <= 16'h0000;
            rx_left_q <= 16'h0000;
            rx_right_q <= 16'h0000;
            codec_ready_q <= 1'b0;
        end else if (en && bclk_fall) begin
            rx_sh_q <= rx_word;
            if (rx_word_end) begin
                case (rx_slot)
                    4'h0: begin
                        rx_tag_q <= rx_word;
                        codec_ready_q <= rx_word[`ACTS_READY_BIT];
                    end
                    4'h1: rx_s1_q <= rx_word;
                    4'h2: rx_s2_q <= rx_word;
                    4'h3: rx_left_q <= rx_word;
                    4'h4: rx_right_q <= rx_word;
                    default: rx_tag_q <= rx_tag_q;
                endcase
            end
        end
    end

    // Tag is decided at receive complete and frozen at the latch point.
    always @(posedge clk_sys) begin
        if (!nrst) begin
            next_tag_q <= `ACTS_INIT_TAG;
            hold_tag_q <= `ACTS_INIT_TAG;
            hold_s1_q <= `ACTS_INIT_ADDR;
            hold_s2_q <= `ACTS_INIT_DATA;
            hold_left_q <= 16'h0000;
            hold_right_q <= 16'h0000;
        end else begin
            if (rx_done) begin
                next_tag_q <= tag_calc;
            end
            if (tag_latch) begin
                // Holding words only feed slots of the frame after this one.
                hold_tag_q <= next_tag_q;
                if (ctrl_q[`ACTS_C_INIT]) begin
                    hold_s1_q <= `ACTS_INIT_ADDR;
                    hold_s2_q <= `ACTS_INIT_DATA;
                end else begin
                    hold_s1_q <= 16'h0000;
                    hold_s2_q <= 16'h0000;
                end
                hold_left_q <= next_tag_q[`ACTS_LEFT_BIT] ?
                    stage_left_q : 16'h0000;
                hold_right_q <= next_tag_q[`ACTS_RIGHT_BIT] ?
                    stage_right_q : 16'h0000;
            end
        end
    end

    // Sample writes land in staging words, so the frame on the wire is safe.
    always @(posedge clk_sys) begin
        if (!nrst) begin
            ctrl_q <= `ACTS_CTRL_RST;
            mask_q <= 3'h0;
            stage_left_q <= 16'h0000;
            stage_right_q <= 16'h0000;
        end else if (reg_wr) begin
            if (reg_addr == `ACTS_A_CTRL) begin
                ctrl_q <= reg_wdata[3:0];
            end
            if (reg_addr == `ACTS_A_MASK) begin
                mask_q <= reg_wdata[2:0];
            end
            if (wr_txl) begin
                stage_left_q <= reg_wdata[15:0];
            end
            if (wr_txr) begin
                stage_right_q <= reg_wdata[15:0];
            end
        end
    end

    // Sticky events; a new event beats a write-one clear in the same cycle.
    always @* begin
        stat_d = stat_q;
        if (reg_wr && (reg_addr == `ACTS_A_STAT)) begin
            stat_d = stat_d & ~reg_wdata[2:0];
        end
        stat_d[`ACTS_I_RXDONE] = stat_d[`ACTS_I_RXDONE] | rx_done;
        stat_d[`ACTS_I_LATCH] = stat_d[`ACTS_I_LATCH] | tag_latch;
        stat_d[`ACTS_I_LATE] = stat_d[`ACTS_I_LATE] | late_wr;
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            stat_q <= 3'h0;
            irq_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq_q <= |(stat_d & mask_q);
        end
    end

    always @* begin
        case (reg_addr)
            `ACTS_A_CTRL: rd_mux = {28'h0000000, ctrl_q};
            `ACTS_A_STAT: rd_mux = {29'h00000000, stat_q};
            `ACTS_A_MASK: rd_mux = {29'h00000000, mask_q};
            `ACTS_A_RXTAG: rd_mux = {16'h0000, rx_tag_q};
            `ACTS_A_RXS1: rd_mux = {16'h0000, rx_s1_q};
            `ACTS_A_RXS2: rd_mux = {16'h0000, rx_s2_q};
            `ACTS_A_RXL: rd_mux = {16'h0000, rx_left_q};
            `ACTS_A_RXR: rd_mux = {16'h0000, rx_right_q};
            `ACTS_A_TXL: rd_mux = {16'h0000, stage_left_q};
            `ACTS_A_TXR: rd_mux = {16'h0000, stage_right_q};
            `ACTS_A_HOLD: rd_mux = {8'h00, cnt_q, hold_tag_q};
            `ACTS_A_NEXT: rd_mux = {16'h0000, next_tag_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always @(posedge clk_sys) begin
        if (!nrst) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata_q <= rd_mux;
        end else begin
            reg_rdata_q <= 32'h00000000;
        end
    end
endmodule

// >>> src/acts_defs.vh
// Constants for the audio link slot and tag sequencer.
`ifndef ACTS_DEFS_VH
`define ACTS_DEFS_VH

// Register byte addresses.
`define ACTS_A_CTRL 8'h00
`define ACTS_A_STAT 8'h04
`define ACTS_A_MASK 8'h08
`define ACTS_A_RXTAG 8'h0C
`define ACTS_A_RXS1 8'h10
`define ACTS_A_RXS2 8'h14
`define ACTS_A_RXL 8'h18
`define ACTS_A_RXR 8'h1C
`define ACTS_A_TXL 8'h20
`define ACTS_A_TXR 8'h24
`define ACTS_A_HOLD 8'h28
`define ACTS_A_NEXT 8'h2C

// Control bit positions and reset value.
`define ACTS_C_EN 0
`define ACTS_C_MODE 1
`define ACTS_C_SEL 2
`define ACTS_C_INIT 3
`define ACTS_CTRL_RST 4'h8

// Interrupt event bit positions.
`define ACTS_I_RXDONE 0
`define ACTS_I_LATCH 1
`define ACTS_I_LATE 2

// Tag and word values.
`define ACTS_TAG_FRAME 16'h8000
`define ACTS_READY_BIT 15
`define ACTS_ADC_MASK 16'h1800
`define ACTS_DRQ_MASK 16'h00C0
`define ACTS_DRQ_SHIFT 5
`define ACTS_LEFT_BIT 12
`define ACTS_RIGHT_BIT 11
`define ACTS_INIT_TAG 16'hE000
`define ACTS_INIT_ADDR 16'h7400
`define ACTS_INIT_DATA 16'hFF80

// Frame geometry, in slots and bit clocks.
`define ACTS_SLOT_BITS 16
`define ACTS_RX_SLOTS 5
`define ACTS_TX_SLOTS 16
`define ACTS_TAG_WINDOW 160
`define ACTS_LEFT_SLOT 4'h3
`define ACTS_RIGHT_SLOT 4'h4
`define ACTS_LAST_RX_SLOT 4'h4

`endif

// >>> src/acts_pin_sync.v
// Two-stage pin synchroniser with edge detection.
`timescale 1ns/1ps
module acts_pin_sync #(
    parameter W = 2
) (
    input wire clk_sys,
    input wire nrst,
    input wire [W-1:0] pin,
    output wire [W-1:0] level,
    output wire [W-1:0] rise,
    output wire [W-1:0] fall
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;
    reg [W-1:0] last_q;

    // Only the second and third stages feed the edge logic.
    always @(posedge clk_sys) begin
        if (!nrst) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
            last_q <= {W{1'b0}};
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~last_q;
    assign fall = ~sync_q & last_q;
endmodule

// >>> dv/acts_seq_properties.sv
// Port-level assertions for the audio link slot and tag sequencer.
`timescale 1ns/1ps
module acts_seq_checker (
    input wire clk_sys,
    input wire nrst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata_q,
    input wire irq_q,
    input wire bit_clk,
    input wire sdata_in,
    input wire sync_q,
    input wire sdata_out_q,
    input wire codec_ready_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    reg [15:0] fc_q;
    // Cycles since the last frame sync rise; it saturates once the link stops.
    always @(posedge clk_sys) begin
        if (!nrst) begin
            fc_q <= 16'hFFFF;
        end else if ($rose(sync_q)) begin
            fc_q <= 16'h0001;
        end else if (fc_q != 16'hFFFF) begin
            fc_q <= fc_q + 16'h0001;
        end
    end
    a_rd_idle_zero: assert property (
        !reg_rd |=> reg_rdata_q == 32'h0) else $error("read data not idle");
    a_sync_width: assert property (
        $fell(sync_q) |-> fc_q >= 16'h018F && fc_q <= 16'h0191)
        else $error("frame sync not one slot long");
    a_frame_length: assert property (
        $rose(sync_q) && fc_q != 16'hFFFF |-> fc_q >= 16'h18FF &&
        fc_q <= 16'h1901) else $error("frame not sixteen slots long");
    a_tail_slots_zero: assert property (
        fc_q >= 16'h07D5 && fc_q <= 16'h18FB |-> !sdata_out_q)
        else $error("data in slots 5 to 15");
    a_sync_on_rise: assert property (
        $rose(sync_q) |-> $past(bit_clk) && !$past(bit_clk, 6))
        else $error("frame sync off the bit clock rise");
    a_bit_on_rise: assert property (
        $changed(sdata_out_q) |-> $past(bit_clk))
        else $error("serial data changed off the bit clock rise");
    a_mask_drops_irq: assert property (
        reg_wr && reg_addr == 8'h08 && reg_wdata[2:0] == 3'h0 |-> ##2 !irq_q)
        else $error("interrupt high with every event masked");
    a_ready_in_rx: assert property (
        $changed(codec_ready_q) |-> fc_q <= 16'h0834)
        else $error("ready flag changed outside the receive slots");
endmodule
bind acts_sequencer acts_seq_checker chk (.clk_sys, .nrst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .irq_q, .bit_clk,
    .sdata_in, .sync_q, .sdata_out_q, .codec_ready_q);

// >>> dv/acts_codec_model.sv
// Behavioural codec on the far side of the serial audio link.
`timescale 1ns/1ps
module acts_codec_model (
    input logic run,
    input logic sync_q,
    input logic sdata_out_q,
    input logic [15:0] rx_w [0:4],
    output logic bit_clk,
    output logic sdata_in,
    output logic [15:0] tx_w [0:15],
    output int frames
);
    logic [15:0] sh = 16'h0;
    logic prev = 1'h0;
    int idx = 300;
    initial begin
        bit_clk = 1'h0;
        sdata_in = 1'h0;
        frames = 0;
    end
    // The bit clock stands still while the bench holds the link idle.
    // A 1 ns offset keeps its edges off the system clock edges, so the
    // synchroniser never meets a zero-time race.
    initial begin
        #1;
        forever begin
            #62.5;
            bit_clk = run ? ~bit_clk : 1'h0;
        end
    end
    // Slots 1 and 2 carry whatever status word the bench loads.
    always @(posedge bit_clk) begin
        #25;
        idx = (sync_q && !prev) ? 0 : idx + 1;
        prev = sync_q;
        // Unused slots toggle, so a stale bit can never pass for data.
        sdata_in = (idx < 80) ? rx_w[idx / 16][15 - idx % 16] : ~sdata_in;
    end
    always @(negedge bit_clk) begin
        if (idx < 256) begin
            sh = {sh[14:0], sdata_out_q};
            if (idx % 16 == 15) tx_w[idx / 16] = sh;
            if (idx == 255) frames++;
        end
    end
endmodule

// >>> dv/test_ac_link_slot_tag_sequencer.sv
// Self-checking bench for the audio link slot and tag sequencer.
`timescale 1ns/1ps
module test_ac_link_slot_tag_sequencer;
    logic clk_sys = 1'h0;
    logic nrst = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic run = 1'h0;
    logic [31:0] reg_rdata_q, q;
    logic irq_q, bit_clk, sdata_in, sync_q, sdata_out_q, codec_ready_q;
    logic [15:0] rx_w [0:4] = '{default: 16'h0};
    logic [15:0] tx_w [0:15];
    int frames;
    int fail_count = 0;
    int checks = 0;
    acts_sequencer dut (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata_q, .irq_q, .bit_clk, .sdata_in, .sync_q,
        .sdata_out_q, .codec_ready_q);
    acts_codec_model codec (.run, .sync_q, .sdata_out_q, .rx_w, .bit_clk,
        .sdata_in, .tx_w, .frames);
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic complete_run();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1;
        q = reg_rdata_q;
    endtask
    // Returns in the last bit of a frame, just before the next frame starts.
    task automatic wait_frames(input int n);
        int f;
        f = frames + n;
        for (int t = 0; t < 7000 * n && frames < f; t++) begin
            @(posedge clk_sys);
        end
        if (frames < f) begin
            fail_count++;
            $display("Error at %0t: no frame from the link", $time);
            complete_run();
        end
    endtask
    task automatic chk_frame(input logic [31:0] t, l, r, input logic init);
        logic [31:0] e;
        for (int i = 0; i < 16; i++) begin
            e = i == 0 ? t : i == 3 ? l : i == 4 ? r : 32'h0;
            if (init && i == 1) e = 32'h7400;
            if (init && i == 2) e = 32'hFF80;
            cmp({16'h0, tx_w[i]}, e);
        end
    endtask
    task automatic s_reset();
        cmp({reg_rdata_q[28:0], irq_q, sync_q, sdata_out_q}, 32'h0);
        rd(8'h00);
        cmp(q, 32'h8);
        rd(8'h28);
        cmp({16'h0, q[15:0]}, 32'hE000);
        rd(8'h30);
        cmp(q, 32'h0);
    endtask
    task automatic s_init();
        wr(8'h08, 32'h3);
        run = 1'h1;
        wr(8'h00, 32'h9);
        wait_frames(2);
        chk_frame(32'hE000, 32'h0, 32'h0, 1'h1);
        cmp({31'h0, irq_q}, 32'h1);
        rd(8'h04);
        cmp(q, 32'h3);
        wr(8'h04, 32'h3);
        rd(8'h04);
        cmp({q[30:0], irq_q}, 32'h0);
        wr(8'h08, 32'h0);
        wait_frames(1);
        cmp({31'h0, irq_q}, 32'h0);
    endtask
    task automatic s_adc();
        rx_w = '{16'h9800, 16'h0, 16'h0, 16'h1111, 16'h2222};
        wr(8'h20, 32'h1234);
        wr(8'h24, 32'h5678);
        // Both sample writes land in slot 15, after the latch point.
        rd(8'h04);
        cmp(q, 32'h7);
        wr(8'h00, 32'h1);
        wait_frames(2);
        rx_w[0] = 16'h0800;
        chk_frame(32'h9800, 32'h1234, 32'h5678, 1'h0);
        cmp({31'h0, codec_ready_q}, 32'h1);
        rd(8'h0C);
        cmp(q, 32'h9800);
        rd(8'h1C);
        cmp(q, 32'h2222);
        wait_frames(2);
        chk_frame(32'h8800, 32'h0, 32'h5678, 1'h0);
        cmp({31'h0, codec_ready_q}, 32'h0);
    endtask
    // Tag bits come from the status slots here, not from the received tag.
    task automatic s_drq();
        rx_w = '{16'h1800, 16'h0040, 16'h0040, 16'h0, 16'h0};
        wr(8'h00, 32'h3);
        wait_frames(2);
        chk_frame(32'h9000, 32'h1234, 32'h0, 1'h0);
        wr(8'h00, 32'h7);
        wait_frames(2);
        chk_frame(32'h8800, 32'h0, 32'h5678, 1'h0);
    endtask
    task automatic s_off();
        logic s;
        s = 1'h0;
        repeat (2400) @(posedge clk_sys);
        wr(8'h00, 32'h0);
        repeat (7000) begin
            @(posedge clk_sys);
            s = s | sync_q | sdata_out_q;
        end
        cmp({31'h0, s}, 32'h0);
        run = 1'h0;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        nrst <= 1'h1;
        @(posedge clk_sys);
        #1;
        s_reset();
        s_init();
        s_adc();
        s_drq();
        s_off();
        complete_run();
    end
endmodule
